// ---- pmt_pkg.sv ----
package pmt_pkg;

  // Memory geometry
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int DM_ADDR_W = 12;

  // Fetch and table addressing
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] LAST_PAGE_HI = 8'hFF;
  localparam logic [7:0] UID_FIRST_OFS = 8'hE8;
  localparam logic [7:0] UID_CRC_OFS = 8'hEF;
  localparam logic [7:0] UID_OPT_FIRST = 8'h28;
  localparam logic [7:0] UID_OPT_LAST = 8'h2F;
  localparam int UID_BYTES = 14;
  localparam int UID_BITS = 128;

  // Table read takes two instruction cycles of one clock each
  localparam int TAB_CYCLES = 2;

  // Identifier check code
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_XOROUT = 16'h0000;

  // Reset values of core-visible bytes
  localparam logic [7:0] TBL_PTR_RST = 8'h00;
  localparam logic [7:0] TBL_HIGH_RST = 8'h00;
  localparam logic OPT_MAP_RST = 1'b0;

  // Serial programming frame: rw bit, 16 address bits, 16 data bits
  localparam int PROG_ADDR_FIRST = 1;
  localparam int PROG_ADDR_LAST = 16;
  localparam int PROG_FRAME_BITS = 33;
  localparam int PROG_CNT_W = 6;

  // Core-side byte register selects
  typedef enum logic [1:0] {
    PMT_SEL_PTR_LO,
    PMT_SEL_PTR_HI,
    PMT_SEL_TBL_HIGH,
    PMT_SEL_OPT_MAP
  } pmt_sel_t;

endpackage

// ---- pmt_crc16.sv ----
`timescale 1ns/1ps

module pmt_crc16
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Byte stream
  input wire logic clear_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Running checksum
  output logic [15:0] crc_o
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // One byte per clock, MSB first, no reflection
  always_comb begin
    crc_d = crc_q ^ {byte_i, 8'h00};
    for (int b = 0; b < 8; b++) begin
      if (crc_d[15]) begin
        crc_d = {crc_d[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc_d = {crc_d[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i) begin
      crc_q <= CRC_INIT;
    end else if (byte_valid_i) begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q ^ CRC_XOROUT;

endmodule

// ---- pmt_table_read.sv ----
`timescale 1ns/1ps

// How it works
// - Program store is 65536 words of 16 bits, for fetch and tables.
// - After reset the fetch address is word zero.
// - A table read may address any program word.
// - Table address is high pointer byte joined to low pointer byte.
// - Low byte of the read word goes to the named data register.
// - High byte of the read word overwrites the table-high latch.
// - Core can read and write the table-high latch.
// - Every table read, normal or last-page, takes two cycles.
// - Last-page form uses all-ones upper byte with low pointer byte.
// - Extended form only differs in destination addressing.
// - The 128-bit identifier is fixed and cannot be changed.
// - Identifier sits at last-page E8 to EF, CRC in the last word.
// - Identifier words are seen only while option mapping is on.
// - CRC-16 uses poly 1021, zero init, no xor, no reflection.
// - CRC takes one byte at a time and updates after each.
// - Serial programming moves address and data on one data pin.
// - On the emulation part, debug pins take over their shared pins.
// - Debug pins still serve as programming pins while debugging.
module pmt_table_read
  import pmt_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  // Arbitrary value, stands in for the factory identifier bytes 0..13
  parameter logic [8*UID_BYTES-1:0] UID_VALUE = 112'h0123456789ABCDEF0123456789AB,
  parameter bit EMU_PART = 1'b0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction fetch
  input wire logic fetch_next_i,
  input wire logic jump_i,
  input wire logic [ADDR_W-1:0] jump_addr_i,
  output logic [ADDR_W-1:0] fetch_addr_o,
  output logic [WORD_W-1:0] fetch_word_o,
  // Core byte registers
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Table read instruction
  input wire logic tab_start_i,
  input wire logic tab_last_page_i,
  input wire logic tab_ext_i,
  input wire logic [DM_ADDR_W-1:0] tab_dest_i,
  output logic tab_busy_o,
  output logic tab_done_o,
  // Data memory write port
  output logic dm_wr_o,
  output logic [DM_ADDR_W-1:0] dm_addr_o,
  output logic [7:0] dm_wdata_o,
  output logic dm_ext_o,
  // Programming and debug pins
  input wire logic prog_en_i,
  input wire logic prog_serial_clock_pin_i,
  input wire logic prog_serial_data_pin_i,
  output logic prog_serial_data_pin_o,
  output logic prog_serial_data_pin_oe_o,
  output logic shared_fn_disable_o,
  // Identifier status
  output logic uid_crc_ready_o
);

  if (DEPTH != (1 << ADDR_W)) begin : gen_depth_chk
    $error("DEPTH must equal the full 16-bit address space");
  end

  // Program store, flip-flops
  logic [WORD_W-1:0] mem_q [DEPTH];
  // Core-visible bytes
  logic [7:0] ptr_lo_q, ptr_hi_q, tbl_high_q, reg_rdata_q;
  logic opt_map_q;
  // Fetch
  logic [ADDR_W-1:0] pc_q;
  logic [WORD_W-1:0] fetch_word_q;
  // Table read sequencing
  typedef enum logic [1:0] {
    TAB_IDLE,
    TAB_READ,
    TAB_WRITE
  } pmt_tab_state_t;
  pmt_tab_state_t tab_state_q;
  logic [ADDR_W-1:0] tab_addr_q;
  logic [DM_ADDR_W-1:0] tab_dest_q, dm_addr_q;
  logic [WORD_W-1:0] tab_word_q;
  logic tab_ext_q, tab_busy_q, tab_done_q, dm_wr_q, dm_ext_q;
  logic [7:0] dm_wdata_q;
  // Identifier check code
  logic [3:0] uid_idx_q;
  logic uid_ready_q, uid_feed;
  logic [15:0] crc_run;
  logic [7:0] uid_byte;
  // Pin synchronisers
  logic [1:0] en_sync_q, ck_sync_q, da_sync_q;
  logic ck_last_q, ck_rise, ck_fall;
  // Serial programming
  logic [PROG_CNT_W-1:0] prog_cnt_q;
  logic [ADDR_W-1:0] prog_addr_q;
  logic [WORD_W-1:0] prog_shift_q;
  logic prog_rd_q, prog_wr_q, prog_do_q, prog_oe_q, shared_dis_q;
  // Table address and identifier overlay
  logic [ADDR_W-1:0] tab_addr_d;
  logic uid_hit;
  logic [WORD_W-1:0] tab_word_d;

  always_comb begin
    if (tab_last_page_i) begin
      tab_addr_d = {LAST_PAGE_HI, ptr_lo_q};
    end else begin
      tab_addr_d = {ptr_hi_q, ptr_lo_q};
    end
  end

  // Identifier words only while mapping is on; else plain store
  assign uid_hit = opt_map_q && (tab_addr_q[15:8] == LAST_PAGE_HI) &&
                   (tab_addr_q[7:0] >= UID_FIRST_OFS) &&
                   (tab_addr_q[7:0] <= UID_CRC_OFS);

  always_comb begin
    tab_word_d = mem_q[tab_addr_q];
    if (uid_hit) begin
      if (tab_addr_q[7:0] == UID_CRC_OFS) begin
        tab_word_d = crc_run;
      end else begin
        tab_word_d = UID_VALUE[16*tab_addr_q[2:0] +: 16];
      end
    end
  end

  // Core byte registers; pointers change only by core writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr_lo_q <= TBL_PTR_RST;
      ptr_hi_q <= TBL_PTR_RST;
      opt_map_q <= OPT_MAP_RST;
    end else if (reg_wr_i) begin
      case (pmt_sel_t'(reg_sel_i))
        PMT_SEL_PTR_LO: ptr_lo_q <= reg_wdata_i;
        PMT_SEL_PTR_HI: ptr_hi_q <= reg_wdata_i;
        PMT_SEL_OPT_MAP: opt_map_q <= reg_wdata_i[0];
        default: ;
      endcase
    end
  end

  // Latch: table read load wins over a core write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tbl_high_q <= TBL_HIGH_RST;
    end else if (tab_state_q == TAB_WRITE) begin
      tbl_high_q <= tab_word_q[15:8];
    end else if (reg_wr_i && (reg_sel_i == PMT_SEL_TBL_HIGH)) begin
      tbl_high_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (pmt_sel_t'(reg_sel_i))
        PMT_SEL_PTR_LO: reg_rdata_q <= ptr_lo_q;
        PMT_SEL_PTR_HI: reg_rdata_q <= ptr_hi_q;
        PMT_SEL_TBL_HIGH: reg_rdata_q <= tbl_high_q;
        PMT_SEL_OPT_MAP: reg_rdata_q <= {7'h00, opt_map_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Instruction fetch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_q <= RESET_VECTOR;
    end else if (jump_i) begin
      pc_q <= jump_addr_i;
    end else if (fetch_next_i) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fetch_word_q <= 16'h0000;
    end else begin
      fetch_word_q <= mem_q[pc_q];
    end
  end

  // Table read: cycle one reads the word, cycle two writes it out
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tab_state_q <= TAB_IDLE;
      tab_addr_q <= 16'h0000;
      tab_dest_q <= '0;
      tab_ext_q <= 1'b0;
      tab_word_q <= 16'h0000;
    end else begin
      case (tab_state_q)
        TAB_IDLE: begin
          // Waits for the check code so the last word is never stale
          if (tab_start_i && uid_ready_q) begin
            tab_addr_q <= tab_addr_d;
            tab_dest_q <= tab_dest_i;
            tab_ext_q <= tab_ext_i;
            tab_state_q <= TAB_READ;
          end
        end
        TAB_READ: begin
          tab_word_q <= tab_word_d;
          tab_state_q <= TAB_WRITE;
        end
        TAB_WRITE: tab_state_q <= TAB_IDLE;
        default: tab_state_q <= TAB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dm_wr_q <= 1'b0;
      dm_addr_q <= '0;
      dm_wdata_q <= 8'h00;
      dm_ext_q <= 1'b0;
      tab_done_q <= 1'b0;
      tab_busy_q <= 1'b0;
    end else begin
      dm_wr_q <= (tab_state_q == TAB_READ);
      tab_done_q <= (tab_state_q == TAB_READ);
      tab_busy_q <= (tab_state_q == TAB_IDLE) ?
                    (tab_start_i && uid_ready_q) :
                    (tab_state_q == TAB_READ);
      if (tab_state_q == TAB_READ) begin
        dm_addr_q <= tab_dest_q;
        dm_ext_q <= tab_ext_q;
        dm_wdata_q <= tab_word_d[7:0];
      end
    end
  end

  // Check code over identifier bytes 0..13 once after reset
  assign uid_feed = !uid_ready_q;
  assign uid_byte = UID_VALUE[8*uid_idx_q +: 8];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      uid_idx_q <= 4'h0;
      uid_ready_q <= 1'b0;
    end else if (uid_feed) begin
      if (uid_idx_q == 4'(UID_BYTES - 1)) begin
        uid_ready_q <= 1'b1;
      end else begin
        uid_idx_q <= uid_idx_q + 4'h1;
      end
    end
  end

  pmt_crc16 u_crc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(1'b0),
    .byte_valid_i(uid_feed),
    .byte_i(uid_byte),
    .crc_o(crc_run)
  );

  // Pins from the programmer pass two flip-flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_sync_q <= 2'b00;
      ck_sync_q <= 2'b00;
      da_sync_q <= 2'b00;
      ck_last_q <= 1'b0;
    end else begin
      en_sync_q <= {en_sync_q[0], prog_en_i};
      ck_sync_q <= {ck_sync_q[0], prog_serial_clock_pin_i};
      da_sync_q <= {da_sync_q[0], prog_serial_data_pin_i};
      ck_last_q <= ck_sync_q[1];
    end
  end

  assign ck_rise = ck_sync_q[1] && !ck_last_q;
  assign ck_fall = !ck_sync_q[1] && ck_last_q;

  // Serial frame: rw, address MSB first, then data in or out
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_sync_q[1]) begin
      prog_cnt_q <= '0;
      prog_rd_q <= 1'b0;
      prog_addr_q <= 16'h0000;
      prog_shift_q <= 16'h0000;
      prog_wr_q <= 1'b0;
    end else begin
      prog_wr_q <= 1'b0;
      if (ck_rise && (prog_cnt_q < PROG_CNT_W'(PROG_FRAME_BITS))) begin
        prog_cnt_q <= prog_cnt_q + 6'd1;
        if (prog_cnt_q == '0) begin
          prog_rd_q <= da_sync_q[1];
        end else if (prog_cnt_q <= PROG_CNT_W'(PROG_ADDR_LAST)) begin
          prog_addr_q <= {prog_addr_q[14:0], da_sync_q[1]};
        end else if (!prog_rd_q) begin
          prog_shift_q <= {prog_shift_q[14:0], da_sync_q[1]};
          prog_wr_q <= (prog_cnt_q == PROG_CNT_W'(PROG_FRAME_BITS - 1));
        end
      end
      // Load with the last address bit so the MSB leaves on the next fall
      if (prog_rd_q && ck_rise &&
          (prog_cnt_q == PROG_CNT_W'(PROG_ADDR_LAST))) begin
        prog_shift_q <= mem_q[{prog_addr_q[14:0], da_sync_q[1]}];
      end else if (prog_rd_q && ck_fall &&
                   (prog_cnt_q > PROG_CNT_W'(PROG_ADDR_LAST))) begin
        prog_shift_q <= {prog_shift_q[14:0], 1'b0};
      end
    end
  end

  // Store written only by the programmer
  always_ff @(posedge clk_i) begin
    if (prog_wr_q) begin
      mem_q[prog_addr_q] <= prog_shift_q;
    end
  end

  // Data pin driven out only during the data half of a read frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_sync_q[1]) begin
      prog_do_q <= 1'b0;
      prog_oe_q <= 1'b0;
    end else if (ck_fall) begin
      prog_oe_q <= prog_rd_q &&
                   (prog_cnt_q > PROG_CNT_W'(PROG_ADDR_LAST)) &&
                   (prog_cnt_q < PROG_CNT_W'(PROG_FRAME_BITS));
      prog_do_q <= prog_shift_q[15];
    end
  end

  // Emulation part gives the pins to debug; programming stays on them
  always_ff @(posedge clk_i) begin
    shared_dis_q <= rst_n_i && EMU_PART;
  end

  assign fetch_addr_o = pc_q;
  assign fetch_word_o = fetch_word_q;
  assign reg_rdata_o = reg_rdata_q;
  assign tab_busy_o = tab_busy_q;
  assign tab_done_o = tab_done_q;
  assign dm_wr_o = dm_wr_q;
  assign dm_addr_o = dm_addr_q;
  assign dm_wdata_o = dm_wdata_q;
  assign dm_ext_o = dm_ext_q;
  assign prog_serial_data_pin_o = prog_do_q;
  assign prog_serial_data_pin_oe_o = prog_oe_q;
  assign shared_fn_disable_o = shared_dis_q;
  assign uid_crc_ready_o = uid_ready_q;

endmodule

// ---- pmt_table_read_monitor.sv ----
`timescale 1ns/1ps
module pmt_table_read_monitor
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fetch
  input wire logic fetch_next_i,
  input wire logic jump_i,
  input wire logic [ADDR_W-1:0] jump_addr_i,
  input wire logic [ADDR_W-1:0] fetch_addr_o,
  // Table read
  input wire logic tab_start_i,
  input wire logic tab_ext_i,
  input wire logic [DM_ADDR_W-1:0] tab_dest_i,
  input wire logic tab_busy_o,
  input wire logic tab_done_o,
  input wire logic dm_wr_o,
  input wire logic [DM_ADDR_W-1:0] dm_addr_o,
  input wire logic dm_ext_o,
  input wire logic uid_crc_ready_o,
  // Pins
  input wire logic prog_en_i,
  input wire logic prog_serial_data_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic take;
  // A start only counts when idle and the check code is done
  assign take = tab_start_i && !tab_busy_o && uid_crc_ready_o;

  chk_reset_vector: assert property (disable iff (1'b0)
    !rst_n_i |=> fetch_addr_o == RESET_VECTOR)
    else $error("fetch address not at reset vector");
  chk_fetch_step: assert property (
    fetch_next_i && !jump_i |=> fetch_addr_o == $past(fetch_addr_o) + 16'h1)
    else $error("fetch address did not advance");
  chk_jump_load: assert property (
    jump_i |=> fetch_addr_o == $past(jump_addr_i))
    else $error("jump target not loaded");
  chk_read_lat: assert property (
    take |-> ##2 (dm_wr_o && tab_done_o))
    else $error("table read not done in two cycles");
  chk_busy_span: assert property (
    $rose(tab_busy_o) |=> (tab_busy_o && dm_wr_o) ##1 (!tab_busy_o && !dm_wr_o))
    else $error("busy span wrong");
  chk_dest_copy: assert property (
    take |-> ##2 (dm_addr_o == $past(tab_dest_i, 2)
      && dm_ext_o == $past(tab_ext_i, 2)))
    else $error("destination not carried");
  chk_wr_pulse: assert property (
    dm_wr_o |-> tab_done_o ##1 !dm_wr_o)
    else $error("write strobe not a single pulse");
  chk_no_early: assert property (
    tab_start_i && !uid_crc_ready_o && !tab_busy_o |=> !tab_busy_o)
    else $error("read taken before check code ready");
  chk_crc_ready: assert property (
    $rose(rst_n_i) |-> !uid_crc_ready_o ##[8:20] uid_crc_ready_o)
    else $error("check code ready timing wrong");
  chk_oe_quiet: assert property (
    !prog_en_i [*6] |-> !prog_serial_data_pin_oe_o)
    else $error("data pin driven outside a frame");

  cover property (take);
  cover property (jump_i);
  cover property (prog_serial_data_pin_oe_o);
endmodule

bind pmt_table_read pmt_table_read_monitor mon (
  .clk_i, .rst_n_i, .fetch_next_i, .jump_i, .jump_addr_i, .fetch_addr_o,
  .tab_start_i, .tab_ext_i, .tab_dest_i, .tab_busy_o, .tab_done_o,
  .dm_wr_o, .dm_addr_o, .dm_ext_o, .uid_crc_ready_o, .prog_en_i,
  .prog_serial_data_pin_oe_o
);

// ---- pmt_prog_model.sv ----
`timescale 1ns/1ps
module pmt_prog_model (
  // Clock
  input wire logic clk_i,
  // Device side of the data pin
  input wire logic dev_d_i,
  input wire logic dev_oe_i,
  // Programmer pins
  output logic en_o,
  output logic sck_o,
  output logic pin_o
);
  logic drv = 1'b0;
  // Programmer lets go whenever the device drives
  assign pin_o = dev_oe_i ? dev_d_i : drv;
  initial begin
    en_o = 1'b0;
    sck_o = 1'b0;
  end
  task automatic wait4();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic frame(input logic rw, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q);
    logic [32:0] bits;
    bits = {rw, a, d};
    q = 16'h0000;
    wait4();
    en_o = 1'b1;
    for (int i = 32; i >= 0; i--) begin
      // Released line toggles so a stale level never reads back
      drv = (rw && i < 16) ? ~drv : bits[i];
      wait4();
      sck_o = 1'b1;
      wait4();
      sck_o = 1'b0;
      wait4();
      if (rw && i >= 1 && i <= 16) q[i-1] = pin_o;
    end
    wait4();
    en_o = 1'b0;
    drv = ~drv;
  endtask
endmodule

// ---- pmt_table_read_tb.sv ----
`timescale 1ns/1ps
module pmt_table_read_tb;
  import pmt_pkg::*;
  typedef struct {
    logic map, lp, ext;
    logic [7:0] hi, lo;
    logic [11:0] dest;
    logic [15:0] exp;
  } pmt_row_t;
  // Arbitrary identifier stand-in
  localparam logic [111:0] UIDV = 112'h0D0C0B0A0908070605040302F001;
  logic clk_i = 1'b0, rst_n_i = 1'b0, fetch_next_i = 1'b0, jump_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, tab_start_i = 1'b0;
  logic tab_last_page_i = 1'b0, tab_ext_i = 1'b0;
  logic [15:0] jump_addr_i = 16'h0000, fetch_addr_o, fetch_word_o, q;
  logic [1:0] reg_sel_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00, v, reg_rdata_o, dm_wdata_o;
  logic [11:0] tab_dest_i = 12'h000, dm_addr_o;
  logic prog_en_i, prog_serial_clock_pin_i, prog_serial_data_pin_i;
  logic tab_busy_o, tab_done_o, dm_wr_o, dm_ext_o, uid_crc_ready_o;
  logic prog_serial_data_pin_o, prog_serial_data_pin_oe_o;
  logic shared_fn_disable_o;
  int error_cnt = 0, n_compared = 0, cyc = 0, cnt;
  pmt_row_t rows[6];

  always #25 clk_i = ~clk_i;

  pmt_table_read #(.UID_VALUE(UIDV), .EMU_PART(1'b0)) dut (
    .clk_i, .rst_n_i, .fetch_next_i, .jump_i, .jump_addr_i, .fetch_addr_o,
    .fetch_word_o, .reg_wr_i, .reg_rd_i, .reg_sel_i, .reg_wdata_i,
    .reg_rdata_o, .tab_start_i, .tab_last_page_i, .tab_ext_i, .tab_dest_i,
    .tab_busy_o, .tab_done_o, .dm_wr_o, .dm_addr_o, .dm_wdata_o, .dm_ext_o,
    .prog_en_i, .prog_serial_clock_pin_i, .prog_serial_data_pin_i,
    .prog_serial_data_pin_o, .prog_serial_data_pin_oe_o,
    .shared_fn_disable_o, .uid_crc_ready_o
  );
  pmt_prog_model prog (
    .clk_i, .dev_d_i(prog_serial_data_pin_o),
    .dev_oe_i(prog_serial_data_pin_oe_o), .en_o(prog_en_i),
    .sck_o(prog_serial_clock_pin_i), .pin_o(prog_serial_data_pin_i)
  );

  function automatic logic [15:0] uid_crc();
    logic [15:0] c;
    c = CRC_INIT;
    for (int b = 0; b < UID_BYTES; b++) begin
      c = c ^ {UIDV[8*b +: 8], 8'h00};
      for (int k = 0; k < 8; k++) begin
        c = c[15] ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      end
    end
    return c ^ CRC_XOROUT;
  endfunction
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic reg_w(input logic [1:0] s, input logic [7:0] d);
    step();
    reg_wr_i = 1'b1;
    reg_sel_i = s;
    reg_wdata_i = d;
    step();
    reg_wr_i = 1'b0;
  endtask
  task automatic reg_r(input logic [1:0] s);
    step();
    reg_rd_i = 1'b1;
    reg_sel_i = s;
    step();
    reg_rd_i = 1'b0;
    v = reg_rdata_o;
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    rows[0] = '{1'b0, 1'b0, 1'b0, 8'h12, 8'h34, 12'h005, 16'hA55A};
    rows[1] = '{1'b0, 1'b1, 1'b1, 8'h00, 8'h06, 12'hFFF, 16'h001A};
    rows[2] = '{1'b0, 1'b1, 1'b0, 8'h00, 8'hE8, 12'h800, 16'hBEEF};
    rows[3] = '{1'b1, 1'b1, 1'b0, 8'h00, 8'hE8, 12'h010, UIDV[15:0]};
    rows[4] = '{1'b1, 1'b0, 1'b1, 8'hFF, 8'hEE, 12'h7FF, UIDV[111:96]};
    rows[5] = '{1'b1, 1'b1, 1'b0, 8'h00, 8'hEF, 12'h000, uid_crc()};
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk("fetch_rst", fetch_addr_o, RESET_VECTOR);
    for (cnt = 0; cnt < 30 && uid_crc_ready_o !== 1'b1; cnt++) step();
    chk("shared_fn", {15'h0, shared_fn_disable_o}, 16'h0);
    prog.frame(1'b0, 16'h1234, 16'hA55A, q);
    prog.frame(1'b0, 16'hFF06, 16'h001A, q);
    prog.frame(1'b0, 16'hFFE8, 16'hBEEF, q);
    prog.frame(1'b1, 16'h1234, 16'h0000, q);
    chk("prog_read", q, 16'hA55A);
    $display("test program pins done");
    for (int r = 0; r < 6; r++) begin
      reg_w(PMT_SEL_OPT_MAP, {7'h00, rows[r].map});
      reg_w(PMT_SEL_PTR_HI, rows[r].hi);
      reg_w(PMT_SEL_PTR_LO, rows[r].lo);
      step();
      tab_start_i = 1'b1;
      tab_last_page_i = rows[r].lp;
      tab_ext_i = rows[r].ext;
      tab_dest_i = rows[r].dest;
      step();
      tab_start_i = 1'b0;
      for (cnt = 0; cnt < 6 && dm_wr_o !== 1'b1; cnt++) step();
      chk("low", {8'h0, dm_wdata_o}, {8'h0, rows[r].exp[7:0]});
      chk("done_busy", {14'h0, tab_done_o, tab_busy_o}, 16'h0003);
      chk("dest", {3'h0, dm_ext_o, dm_addr_o},
          {3'h0, rows[r].ext, rows[r].dest});
      reg_r(PMT_SEL_TBL_HIGH);
      chk("latch", {8'h0, v}, {8'h0, rows[r].exp[15:8]});
      reg_r(PMT_SEL_PTR_LO);
      chk("ptr_lo", {8'h0, v}, {8'h0, rows[r].lo});
    end
    $display("test table rows done");
    step();
    jump_i = 1'b1;
    jump_addr_i = 16'h1233;
    step();
    jump_i = 1'b0;
    fetch_next_i = 1'b1;
    step();
    fetch_next_i = 1'b0;
    chk("fetch_addr", fetch_addr_o, 16'h1234);
    step();
    chk("fetch_word", fetch_word_o, 16'hA55A);
    reg_w(PMT_SEL_TBL_HIGH, 8'h3C);
    reg_r(PMT_SEL_TBL_HIGH);
    chk("latch_rw", {8'h0, v}, 16'h003C);
    $display("test fetch and latch done");
    // Start held through busy: only the idle edges may take it
    step();
    tab_start_i = 1'b1;
    cnt = 0;
    for (int k = 0; k < 10; k++) begin
      step();
      if (k == 3) tab_start_i = 1'b0;
      if (dm_wr_o === 1'b1) cnt++;
    end
    chk("b2b_count", cnt[15:0], 16'h0002);
    step();
    tab_start_i = 1'b1;
    step();
    tab_start_i = 1'b0;
    rst_n_i = 1'b0;
    step();
    step();
    chk("rst_fetch", fetch_addr_o, RESET_VECTOR);
    rst_n_i = 1'b1;
    tab_start_i = 1'b1;
    step();
    tab_start_i = 1'b0;
    cnt = 0;
    repeat (6) begin
      step();
      if (dm_wr_o === 1'b1) cnt++;
    end
    chk("early_read", cnt[15:0], 16'h0000);
    $display("test reset mid read done");
    final_report();
  end
endmodule
